/* File: logic/ssw_pkg.sv */
/*
  Package for the supply supervisor: timing constants, variant codes and carrier structs.
  Assumes a 200 MHz clock and digitised comparator results arriving as plain levels.
*/
package ssw_pkg;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int unsigned CLK_PERIOD_PS   = 5000;
  localparam int unsigned RST_DELAY_MS    = 130;
  localparam int unsigned RST_DELAY_MIN_MS = 65;
  localparam int unsigned RST_DELAY_MAX_MS = 195;
  localparam int unsigned WDT_TIMEOUT_MS  = 1100;
  localparam int unsigned WDT_MIN_MS      = 550;
  localparam int unsigned WDT_MAX_MS      = 1650;
  localparam longint unsigned RST_DELAY_CYC =
    (longint'(RST_DELAY_MS) * 64'd1000000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam longint unsigned WDT_TIMEOUT_CYC =
    (longint'(WDT_TIMEOUT_MS) * 64'd1000000000) / CLK_PERIOD_PS;

  // Synchroniser depth.
  localparam int unsigned SYNC_STAGES = 2;

  // ***************************************************************
  // Variants
  // ***************************************************************
  typedef enum logic [1:0] {
    SSW_VAR_PFAIL,
    SSW_VAR_DUAL,
    SSW_VAR_WDOG
  } ssw_variant_t;

  // ***************************************************************
  // Carriers
  // ***************************************************************
  typedef struct packed {
    logic supply_ok;
    logic sense_ok;
    logic pfail_ok;
    logic manual_reset_n;
    logic watchdog_kick_in;
  } ssw_inputs_t;

  typedef struct packed {
    logic reset_n;
    logic supply_reset_n;
    logic aux_reset_n;
    logic power_fail_out;
  } ssw_outputs_t;

endpackage

/* File: logic/ssw_delay.sv */
/*
  Reset stretcher: holds its output low while the cause is present and for a
  delay afterwards; any new cause restarts the delay.
  Assumes a synchronous cause input in the clk_i domain.
*/
`timescale 1ns/1ps
module ssw_delay #(
  parameter longint unsigned DELAY_CYC = ssw_pkg::RST_DELAY_CYC
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Cause and stretched output
  input  wire logic cause_i,
  output logic      rst_n_o
);
  import ssw_pkg::*;

  localparam int W = $clog2(DELAY_CYC + 1);
  localparam logic [W-1:0] LAST = W'(DELAY_CYC - 1);

  logic [W-1:0] cnt_q;
  logic         rst_n_q;

  // The count restarts on every cause cycle, so a bouncing input is absorbed.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || cause_i)
    begin
      cnt_q   <= '0;
      rst_n_q <= 1'b0;
    end
    else if (!rst_n_q)
    begin
      if (cnt_q == LAST)
        rst_n_q <= 1'b1;
      else
        cnt_q <= cnt_q + 1'b1;
    end
  end

  assign rst_n_o = rst_n_q;
endmodule

/* File: logic/ssw_top.sv */
/*
  Supply supervisor core with optional dual outputs or watchdog, chosen by VARIANT.
  Assumes comparator results and pins are digitised levels; they are resynchronised here.
*/
`timescale 1ns/1ps
module ssw_top
  import ssw_pkg::*;
#(
  parameter ssw_variant_t    VARIANT     = SSW_VAR_WDOG,
  parameter longint unsigned DELAY_CYC   = ssw_pkg::RST_DELAY_CYC,
  parameter longint unsigned TIMEOUT_CYC = ssw_pkg::WDT_TIMEOUT_CYC
) (
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // Comparator results and pins
  input  wire ssw_pkg::ssw_inputs_t  in_i,
  // Outputs
  output ssw_pkg::ssw_outputs_t      out_o
);
  import ssw_pkg::*;

  // ***************************************************************
  // Variant decoding
  // ***************************************************************
  // Every variant test goes through this one function, so the output muxes,
  // the watchdog enable and the assertions cannot disagree about a variant.
  function automatic logic var_is(input ssw_variant_t v);
    return VARIANT == v;
  endfunction

  // ***************************************************************
  // Input synchronisers
  // ***************************************************************
  localparam int NIN = $bits(ssw_inputs_t);
  logic [NIN-1:0] sync_a_q;
  logic [NIN-1:0] sync_b_q;
  ssw_inputs_t    s;

  // Two flops per bit; the first stage feeds only the second.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync_a_q <= '0;
      sync_b_q <= '0;
    end
    else
    begin
      sync_a_q <= in_i;
      sync_b_q <= sync_a_q;
    end
  end
  assign s = ssw_inputs_t'(sync_b_q);

  // ***************************************************************
  // Watchdog
  // ***************************************************************
  localparam int WW = $clog2(TIMEOUT_CYC + 1);
  localparam logic [WW-1:0] WLAST = WW'(TIMEOUT_CYC - 1);
  logic [WW-1:0] wdt_q;
  logic          kick_q;
  logic          kick_edge;
  logic          wdt_fire_q;
  logic          any_rst_n;
  logic          wd_on;

  assign wd_on     = var_is(SSW_VAR_WDOG);
  assign kick_edge = s.watchdog_kick_in ^ kick_q;

  // Previous kick level for edge detection on the synchronised signal.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      kick_q <= 1'b0;
    else
      kick_q <= s.watchdog_kick_in;
  end

  // Timer clears during reset and on either kick edge; expiry pulses once.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !wd_on || !any_rst_n || kick_edge || wdt_fire_q)
    begin
      wdt_q      <= '0;
      wdt_fire_q <= 1'b0;
    end
    else if (wdt_q == WLAST)
    begin
      wdt_fire_q <= 1'b1;
      wdt_q      <= '0;
    end
    else
      wdt_q <= wdt_q + 1'b1;
  end

  // ***************************************************************
  // Reset causes
  // ***************************************************************
  logic supply_cause;
  logic aux_cause;
  logic main_cause;
  logic supply_rst_n;
  logic aux_rst_n;
  logic main_rst_n;

  // Power-fail never appears in any cause term.
  assign supply_cause = !s.manual_reset_n || !s.supply_ok;
  assign aux_cause    = !s.manual_reset_n || !s.sense_ok;
  assign main_cause   = wd_on ? (supply_cause || !s.sense_ok || wdt_fire_q)
                              : supply_cause;

  ssw_delay #(.DELAY_CYC(DELAY_CYC)) u_sup (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .cause_i (supply_cause),
    .rst_n_o (supply_rst_n)
  );

  ssw_delay #(.DELAY_CYC(DELAY_CYC)) u_aux (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .cause_i (aux_cause),
    .rst_n_o (aux_rst_n)
  );

  ssw_delay #(.DELAY_CYC(DELAY_CYC)) u_main (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .cause_i (main_cause),
    .rst_n_o (main_rst_n)
  );

  assign any_rst_n = main_rst_n;

  // ***************************************************************
  // Outputs
  // ***************************************************************
  logic pfo_q;

  // Power-fail flag follows the comparison directly, not through a stretcher.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pfo_q <= 1'b0;
    else
      pfo_q <= var_is(SSW_VAR_PFAIL) && s.pfail_ok;
  end

  assign out_o.reset_n        = var_is(SSW_VAR_DUAL) ? 1'b0 : main_rst_n;
  assign out_o.supply_reset_n = var_is(SSW_VAR_DUAL) ? supply_rst_n : 1'b0;
  assign out_o.aux_reset_n    = var_is(SSW_VAR_DUAL) ? aux_rst_n : 1'b0;
  assign out_o.power_fail_out = pfo_q;

  // ***************************************************************
  // Assertions
  // ***************************************************************
  sequence cause_seen;
    supply_cause;
  endsequence

  // Expiry is one cycle of the fire flag; the restart is the reset that it
  // causes together with a timer that has been cleared.
  sequence wd_expiry;
    wdt_fire_q;
  endsequence

  sequence wd_restart;
    !main_rst_n && (wdt_q == '0);
  endsequence

  a_manual_holds: assert property (@(posedge clk_i) disable iff (rst_i)
    !s.manual_reset_n |=> !supply_rst_n)
    else $error("reset released while manual reset low");

  a_supply_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    cause_seen ##1 !supply_cause |-> !supply_rst_n)
    else $error("supply reset released too soon");

  a_aux_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(aux_cause) |-> !aux_rst_n)
    else $error("aux reset released too soon");

  a_pfo_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    var_is(SSW_VAR_PFAIL) |=> (pfo_q == $past(s.pfail_ok)))
    else $error("power-fail output does not follow input");

  a_wd_and: assert property (@(posedge clk_i) disable iff (rst_i)
    wd_on && !s.sense_ok |=> !main_rst_n)
    else $error("reset high while sense low");

  a_wd_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    kick_edge |=> (wdt_q == '0))
    else $error("watchdog not cleared by kick edge");

  a_wd_fire: assert property (@(posedge clk_i) disable iff (rst_i)
    wd_expiry |=> wd_restart)
    else $error("watchdog expiry did not reset");

  a_aux_indep: assert property (@(posedge clk_i) disable iff (rst_i)
    !aux_rst_n && $past(aux_rst_n) |-> $past(aux_cause))
    else $error("aux reset dropped without its cause");

  a_pf_noreset: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(main_rst_n) |-> $past(main_cause))
    else $error("reset asserted without cause");

  a_supply_indep: assert property (@(posedge clk_i) disable iff (rst_i)
    !supply_rst_n && $past(supply_rst_n) |-> $past(supply_cause))
    else $error("supply reset dropped without its cause");

  // A supply drop must pull the main reset down in both single-output variants.
  a_supply_main: assert property (@(posedge clk_i) disable iff (rst_i)
    !var_is(SSW_VAR_DUAL) && !s.supply_ok |=> !main_rst_n)
    else $error("main reset high while supply low");

  a_dual_off: assert property (@(posedge clk_i) disable iff (rst_i)
    var_is(SSW_VAR_DUAL) |-> !out_o.reset_n)
    else $error("main reset driven in the dual variant");

  a_wd_held: assert property (@(posedge clk_i) disable iff (rst_i)
    !any_rst_n |=> (wdt_q == '0) && !wdt_fire_q)
    else $error("watchdog ran while reset asserted");

  a_wd_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    wd_expiry |=> !wdt_fire_q)
    else $error("watchdog expiry longer than one cycle");

  a_pfo_unused: assert property (@(posedge clk_i) disable iff (rst_i)
    !var_is(SSW_VAR_PFAIL) |-> !pfo_q)
    else $error("power-fail output driven in a variant without it");

  // The first two edges after reset still show flushed stages, so they are skipped.
  a_sync_latency: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) && !$past(rst_i, 2) |-> (sync_b_q == $past(in_i, 2)))
    else $error("input synchroniser latency is not two cycles");

  // ***************************************************************
  // Release timing checkers
  // ***************************************************************
  // Each stretcher gets its own count of quiet cycles since its cause was last
  // seen. It saturates, so it stays meaningful however long the inputs are good.
  localparam int DW = $clog2(DELAY_CYC + 2);
  localparam logic [DW-1:0] DFULL  = DW'(DELAY_CYC + 1);
  localparam logic [DW-1:0] DEXACT = DW'(DELAY_CYC);
  logic [2:0] chk_cause;
  logic [2:0] chk_rst_n;

  assign chk_cause = {main_cause, aux_cause, supply_cause};
  assign chk_rst_n = {main_rst_n, aux_rst_n, supply_rst_n};

  for (genvar gi = 0; gi < 3; gi++)
  begin : g_quiet
    logic [DW-1:0] quiet_q;

    // Cleared by any cause cycle, like the stretcher, but counted apart from it.
    always_ff @(posedge clk_i)
    begin
      if (rst_i || chk_cause[gi])
        quiet_q <= '0;
      else if (quiet_q != DFULL)
        quiet_q <= quiet_q + 1'b1;
    end

    a_release_exact: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(chk_rst_n[gi]) |-> (quiet_q == DEXACT))
      else $error("reset released after the wrong delay");

    a_release_late: assert property (@(posedge clk_i) disable iff (rst_i)
      (quiet_q == DFULL) |-> chk_rst_n[gi])
      else $error("reset still low after the full delay");
  end

  // Independent count of cycles since the timer was last told to clear, by a
  // kick edge or by an asserted reset. Expiry must land exactly on the timeout.
  localparam int KW = $clog2(TIMEOUT_CYC + 3);
  localparam logic [KW-1:0] KFULL  = KW'(TIMEOUT_CYC + 2);
  localparam logic [KW-1:0] KLATE  = KW'(TIMEOUT_CYC + 1);
  localparam logic [KW-1:0] KEXACT = KW'(TIMEOUT_CYC);
  logic [KW-1:0] kick_quiet_q;

  // Saturates, so a variant without a watchdog leaves it parked and harmless.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || kick_edge || !any_rst_n)
      kick_quiet_q <= '0;
    else if (kick_quiet_q != KFULL)
      kick_quiet_q <= kick_quiet_q + 1'b1;
  end

  a_wd_timeout: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(wdt_fire_q) |-> (kick_quiet_q == KEXACT))
    else $error("watchdog expired after the wrong time");

  a_wd_late: assert property (@(posedge clk_i) disable iff (rst_i)
    wd_on && (kick_quiet_q == KLATE) |-> !any_rst_n)
    else $error("watchdog missed a stuck kick input");
endmodule

/* File: bench/ssw_host_model.sv */
/*
  Host model: toggles the watchdog kick while run_i is high.
  Assumes the supervisor clock; drives on the falling edge.
*/
`timescale 1ns/1ps
module ssw_host_model #(
  parameter int PERIOD = 8
) (
  // Clock
  input  wire logic clk_i,
  // Control and kick
  input  wire logic run_i,
  output logic      kick_o
);
  int   cnt    = 0;
  logic kick_q = 1'b0;

  // Kick well inside the timeout; when stopped the level is frozen, which is
  // the stuck host that the watchdog has to catch.
  always @(negedge clk_i)
  begin
    cnt <= (cnt >= PERIOD - 1) ? 0 : cnt + 1;
    if (run_i && cnt == 0)
      kick_q <= ~kick_q;
  end

  assign kick_o = kick_q;
endmodule

/* File: bench/ssw_top_tb.sv */
/*
  Bench for the supervisor core: all three variants share one set of inputs.
  Assumes shortened delay and timeout parameters.
*/
`timescale 1ns/1ps
module ssw_top_tb;
  import ssw_pkg::*;
  localparam longint unsigned DC = 20;
  localparam longint unsigned TO = 50;
  logic         clk_i;
  logic         rst_i;
  logic         sup;
  logic         sen;
  logic         pf;
  logic         mr;
  logic         run;
  wire          kick;
  ssw_inputs_t  in_s;
  ssw_outputs_t o_w;
  ssw_outputs_t o_d;
  ssw_outputs_t o_p;
  int           n_errors = 0;
  int           n_checks = 0;

  // ***************************************************************
  // Structure
  // ***************************************************************
  assign in_s = {sup, sen, pf, mr, kick};
  ssw_top #(.VARIANT(SSW_VAR_WDOG), .DELAY_CYC(DC), .TIMEOUT_CYC(TO)) u_ssw_top_w (
    .clk_i(clk_i), .rst_i(rst_i), .in_i(in_s), .out_o(o_w));
  ssw_top #(.VARIANT(SSW_VAR_DUAL), .DELAY_CYC(DC), .TIMEOUT_CYC(TO)) u_ssw_top_d (
    .clk_i(clk_i), .rst_i(rst_i), .in_i(in_s), .out_o(o_d));
  ssw_top #(.VARIANT(SSW_VAR_PFAIL), .DELAY_CYC(DC), .TIMEOUT_CYC(TO)) u_ssw_top_p (
    .clk_i(clk_i), .rst_i(rst_i), .in_i(in_s), .out_o(o_p));
  ssw_host_model #(.PERIOD(8)) u_ssw_host_model (
    .clk_i(clk_i), .run_i(run), .kick_o(kick));

  // ***************************************************************
  // Helpers
  // ***************************************************************
  // Clock at 200 MHz.
  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  task automatic chk(input logic got, input logic exp, input string m);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask

  task automatic results();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ***************************************************************
  // Scenarios
  // ***************************************************************
  task automatic t_pfo();
    pf = 1'b0;
    cyc(6);
    chk(o_p.power_fail_out, 1'b0, "pfo low");
    chk(o_p.reset_n, 1'b1, "pfo hit reset");
    pf = 1'b1;
    cyc(3);
    chk(o_p.power_fail_out, 1'b1, "pfo high");
    chk(o_w.power_fail_out, 1'b0, "pfo w unused");
    chk(o_d.power_fail_out, 1'b0, "pfo d unused");
    chk(o_d.reset_n, 1'b0, "d main unused");
    chk(o_w.aux_reset_n, 1'b0, "w aux unused");
    chk(o_p.supply_reset_n, 1'b0, "p sup unused");
    $display("t_pfo done");
  endtask

  task automatic t_mr();
    repeat (3)
    begin
      mr = 1'b0;
      cyc(3);
      mr = 1'b1;
      cyc(3);
    end
    cyc(int'(DC) - 6);
    chk(o_w.reset_n, 1'b0, "mr early w");
    chk(o_d.supply_reset_n, 1'b0, "mr early s");
    chk(o_d.aux_reset_n, 1'b0, "mr early a");
    chk(o_p.reset_n, 1'b0, "mr early p");
    cyc(12);
    chk(o_w.reset_n, 1'b1, "mr late w");
    chk(o_d.aux_reset_n, 1'b1, "mr late a");
    $display("t_mr done");
  endtask

  task automatic t_dual();
    sen = 1'b0;
    cyc(6);
    chk(o_d.aux_reset_n, 1'b0, "aux low");
    chk(o_d.supply_reset_n, 1'b1, "sup by sense");
    chk(o_w.reset_n, 1'b0, "wdog sense");
    sen = 1'b1;
    cyc(int'(DC) - 3);
    chk(o_d.aux_reset_n, 1'b0, "aux early");
    cyc(12);
    chk(o_d.aux_reset_n, 1'b1, "aux late");
    sup = 1'b0;
    cyc(6);
    chk(o_d.supply_reset_n, 1'b0, "sup low");
    chk(o_d.aux_reset_n, 1'b1, "aux by sup");
    sup = 1'b1;
    cyc(5);
    sup = 1'b0;
    cyc(3);
    sup = 1'b1;
    cyc(int'(DC) - 3);
    chk(o_d.supply_reset_n, 1'b0, "sup restart");
    cyc(12);
    chk(o_d.supply_reset_n, 1'b1, "sup late");
    $display("t_dual done");
  endtask

  task automatic t_wdog();
    int   n;
    logic ok;
    run = 1'b0;
    n = 0;
    ok = 1'b1;
    while (o_w.reset_n === 1'b1 && n < int'(TO) + 20)
    begin
      cyc(1);
      n++;
    end
    chk(n > int'(TO) - 15 && n < int'(TO) + 10, 1'b1, "wdog fire");
    cyc(int'(DC) - 6);
    chk(o_w.reset_n, 1'b0, "wdog hold");
    run = 1'b1;
    cyc(15);
    chk(o_w.reset_n, 1'b1, "wdog release");
    repeat (3 * int'(TO))
    begin
      cyc(1);
      ok &= (o_w.reset_n === 1'b1);
    end
    chk(ok, 1'b1, "kick ignored");
    $display("t_wdog done");
  endtask

  // ***************************************************************
  // Sequence and watchdog
  // ***************************************************************
  // Inputs are driven on the falling edge, away from the sampling edge.
  initial
  begin
    rst_i = 1'b1;
    sup = 1'b1;
    sen = 1'b1;
    pf = 1'b1;
    mr = 1'b1;
    run = 1'b0;
    cyc(8);
    rst_i = 1'b0;
    run = 1'b1;
    cyc(int'(DC) + 10);
    chk(o_w.reset_n, 1'b1, "boot");
    t_pfo();
    t_mr();
    t_dual();
    t_wdog();
    results();
  end

  // The tests take well under a thousand cycles.
  initial
  begin
    repeat (3000) @(posedge clk_i);
    n_errors++;
    results();
  end
endmodule
